// *** rtl/ext_bus_pkg.sv ***
package ext_bus_pkg;

  // ----------------------------------------------------------------
  // Clocking and widths
  // ----------------------------------------------------------------
  localparam int PCLK_PERIOD_NS    = 5;
  localparam int TIM_CLK_PERIOD_NS = 20;
  // Least time, so round up to whole pclk cycles
  localparam int TIM_DIV           = (TIM_CLK_PERIOD_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
  localparam int ADDR_W            = 20;
  localparam int DATA_W            = 32;
  localparam int CNT_W             = 4;
  localparam int PADDR_W           = 12;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [PADDR_W-1:0] OFS_TIMING = 12'h000;
  localparam logic [PADDR_W-1:0] OFS_ADDR   = 12'h004;
  localparam logic [PADDR_W-1:0] OFS_WDATA  = 12'h008;
  localparam logic [PADDR_W-1:0] OFS_CMD    = 12'h00c;
  localparam logic [PADDR_W-1:0] OFS_STATUS = 12'h010;
  localparam logic [PADDR_W-1:0] OFS_RDATA  = 12'h014;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CMD_START_BIT   = 0;
  localparam int CMD_WRITE_BIT   = 1;
  localparam int STAT_BUSY_BIT   = 0;
  localparam int STAT_DONE_BIT   = 1;
  localparam int ASYNC_EARLY     = 2;
  localparam logic [31:0] TIMING_RST = 32'h0813_1131;

  // Zone timing configuration, one aligned word
  typedef struct packed {
    logic [3:0]       reserved;
    logic             bus32;
    logic             timing_doubler_setting;
    logic             ready_sampling_style;
    logic             ready_use_setting;
    logic [CNT_W-1:0] write_trail_cycles;
    logic [CNT_W-1:0] write_active_cycles;
    logic [CNT_W-1:0] write_lead_cycles;
    logic [CNT_W-1:0] read_trail_cycles;
    logic [CNT_W-1:0] read_active_cycles;
    logic [CNT_W-1:0] read_lead_cycles;
  } zone_timing_config_s;

  // Control pins of the external bus, all registered
  typedef struct packed {
    logic              zone_select_output_n;
    logic              read_strobe_output_n;
    logic              lower_write_strobe_n;
    logic              upper_write_strobe;
    logic              read_write_direction;
    logic [ADDR_W-1:0] addr;
  } bus_pins_s;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ALIGN,
    SEQ_STROBE,
    SEQ_TRAIL
  } seq_state_e;

endpackage

// *** rtl/ext_bus_ready_wait_sequencer.sv ***
// Behaviour
// R1 - Lead phase starts only on bus clock rise
// R2 - Insert one alignment cycle when misaligned
// R3 - Alignment cycle drives all controls inactive
// R4 - Idle address holds; lowest line stays high
// R5 - Upper strobe only in 32-bit; else A0
// R6 - Sync ready first sampled at lead+active
// R7 - Ready high finishes; low extends, resample
// R8 - Async ready sampled two cycles earlier
// R9 - Drive data with strobe, release after direction
// R10 - Write data held through trail phase
// R11 - Ready ignored when ready-use is cleared
// R12 - Ready-use enables sampling; mode picks style
`timescale 1ns/100ps
module ext_bus_ready_wait_sequencer
  import ext_bus_pkg::*;
#(
  parameter int TIM_DIV_P = ext_bus_pkg::TIM_DIV
) (
  input  wire logic                             pclk,
  input  wire logic                             presetn,
  input  wire logic [ext_bus_pkg::PADDR_W-1:0]  paddr,
  input  wire logic                             psel,
  input  wire logic                             penable,
  input  wire logic                             pwrite,
  input  wire logic [31:0]                      pwdata,
  output logic                                  pready,
  output logic      [31:0]                      prdata,
  output logic                                  pslverr,
  input  wire logic                             external_ready_input,
  input  wire logic [ext_bus_pkg::DATA_W-1:0]   bus_data_in,
  output logic      [ext_bus_pkg::DATA_W-1:0]   bus_data_out,
  output logic                                  bus_data_oe,
  output logic                                  bus_clock_output,
  output ext_bus_pkg::bus_pins_s                bus_pins
);
  import ext_bus_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  zone_timing_config_s cfg_ff;
  seq_state_e          state_ff;
  logic [ADDR_W-1:0]   acc_addr_ff;
  logic [DATA_W-1:0]   wdata_ff;
  logic [DATA_W-1:0]   rdata_ff;
  logic                pend_ff;
  logic                is_write_ff;
  logic                done_ff;
  logic                phase_ff;
  logic [CNT_W+1:0]    pos_ff;
  logic [CNT_W-1:0]    trail_ff;
  logic                ready_s;
  logic [DATA_W-1:0]   data_s;
  logic                tick;
  logic                first_half;
  logic                rise_pt;
  logic                apb_wr;
  logic                start_req;
  logic                busy;
  logic [CNT_W+1:0]    lead_n;
  logic [CNT_W+1:0]    total_n;
  logic [CNT_W+1:0]    sample_pt;
  logic [CNT_W+1:0]    elapsed;
  logic [CNT_W-1:0]    trail_n;
  logic                hold_wait;
  logic                finish;
  logic                in_access;
  logic                in_active;

  initial begin
    if (TIM_DIV_P < 2) $error("TIM_DIV_P must be at least 2");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and timing-clock divider
  // ----------------------------------------------------------------
  sync2 #(.WIDTH(1)) u_ready_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (external_ready_input),
    .q       (ready_s)
  );

  // Data is stable by the time ready is seen, so a per-bit sync is safe
  sync2 #(.WIDTH(DATA_W)) u_data_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (bus_data_in),
    .q       (data_s)
  );

  tim_tick_div #(.DIV(TIM_DIV_P)) u_tick (
    .pclk       (pclk),
    .presetn    (presetn),
    .tick       (tick),
    .first_half (first_half)
  );

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign apb_wr    = psel && penable && pready && pwrite;
  assign busy      = pend_ff || (state_ff != SEQ_IDLE);
  // A start while busy is dropped rather than queued
  assign start_req = apb_wr && (paddr == OFS_CMD) && pwdata[CMD_START_BIT] && !busy;

  // Zero-wait answer: ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= '0;
      if (psel && !penable) begin
        case (paddr)
          OFS_TIMING: prdata <= cfg_ff;
          OFS_ADDR:   prdata <= {{(32-ADDR_W){1'b0}}, acc_addr_ff};
          OFS_WDATA:  prdata <= wdata_ff;
          OFS_CMD:    prdata <= '0;
          OFS_STATUS: prdata <= {30'h0, done_ff, busy};
          OFS_RDATA:  prdata <= rdata_ff;
          default:    pslverr <= 1'b1;
        endcase
      end
    end
  end

  // Software-written configuration and request registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_ff      <= TIMING_RST;
      acc_addr_ff <= '0;
      wdata_ff    <= '0;
      is_write_ff <= 1'b0;
    end else if (apb_wr) begin
      case (paddr)
        OFS_TIMING: cfg_ff      <= {4'h0, pwdata[27:0]};
        OFS_ADDR:   acc_addr_ff <= pwdata[ADDR_W-1:0];
        OFS_WDATA:  wdata_ff    <= pwdata;
        OFS_CMD:    if (start_req) is_write_ff <= pwdata[CMD_WRITE_BIT];
        default:    ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Timing derived from the configuration
  // ----------------------------------------------------------------
  always_comb begin
    logic [CNT_W-1:0] lead_raw;
    logic [CNT_W-1:0] act_raw;
    lead_raw = is_write_ff ? cfg_ff.write_lead_cycles : cfg_ff.read_lead_cycles;
    act_raw  = is_write_ff ? cfg_ff.write_active_cycles : cfg_ff.read_active_cycles;
    trail_n  = is_write_ff ? cfg_ff.write_trail_cycles : cfg_ff.read_trail_cycles;
    // Lead of zero is not legal; treat it as one
    lead_n   = (lead_raw == '0) ? (CNT_W+2)'(1) : (CNT_W+2)'(lead_raw);
    total_n  = lead_n + (CNT_W+2)'(act_raw);
    // R6 sync sample point
    sample_pt = total_n;
    // R8 async sample two cycles early
    if (cfg_ff.ready_sampling_style) begin
      sample_pt = (total_n > (CNT_W+2)'(ASYNC_EARLY)) ? total_n - (CNT_W+2)'(ASYNC_EARLY)
                                                   : (CNT_W+2)'(1);
    end
  end

  assign elapsed = pos_ff + 1'b1;
  // R12 ready-use gates sampling
  // R11 ready ignored when unused
  assign hold_wait = cfg_ff.ready_use_setting && (elapsed == sample_pt) && !ready_s;
  // R7 finish only once ready seen
  assign finish    = tick && (state_ff == SEQ_STROBE) && !hold_wait && (elapsed >= total_n);
  assign in_access = (state_ff == SEQ_STROBE) || (state_ff == SEQ_TRAIL);
  assign in_active = (state_ff == SEQ_STROBE) && (pos_ff >= lead_n);

  // ----------------------------------------------------------------
  // Bus clock phase; rising edge opens a cycle when phase is zero
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 1'b0;
    end else if (tick) begin
      phase_ff <= cfg_ff.timing_doubler_setting ? !phase_ff : 1'b0;
    end
  end

  // True when the coming timing cycle starts with a bus clock rise
  assign rise_pt = !cfg_ff.timing_doubler_setting || phase_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clock_output <= 1'b0;
    end else begin
      bus_clock_output <= cfg_ff.timing_doubler_setting ? !phase_ff : first_half;
    end
  end

  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= SEQ_IDLE;
      pos_ff   <= '0;
      trail_ff <= '0;
    end else if (tick) begin
      case (state_ff)
        SEQ_IDLE: begin
          if (pend_ff) begin
            pos_ff <= '0;
            // R1 lead on rising edge
            // R2 otherwise one alignment cycle
            state_ff <= rise_pt ? SEQ_STROBE : SEQ_ALIGN;
          end
        end
        SEQ_ALIGN: begin
          if (rise_pt) state_ff <= SEQ_STROBE;
        end
        SEQ_STROBE: begin
          // R7 low ready extends active phase
          if (hold_wait) begin
            pos_ff <= pos_ff;
          end else if (elapsed >= total_n) begin
            trail_ff <= trail_n;
            state_ff <= (trail_n == '0) ? SEQ_IDLE : SEQ_TRAIL;
          end else begin
            pos_ff <= elapsed;
          end
        end
        SEQ_TRAIL: begin
          if (trail_ff <= CNT_W'(1)) state_ff <= SEQ_IDLE;
          else trail_ff <= trail_ff - 1'b1;
        end
        default: state_ff <= SEQ_IDLE;
      endcase
    end
  end

  // Pending request, done flag and captured read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff  <= 1'b0;
      done_ff  <= 1'b0;
      rdata_ff <= '0;
    end else begin
      if (start_req) begin
        pend_ff <= 1'b1;
        done_ff <= 1'b0;
      end else if (tick && (state_ff == SEQ_IDLE)) begin
        pend_ff <= 1'b0;
      end
      if (finish) begin
        done_ff <= 1'b1;
        if (!is_write_ff) rdata_ff <= data_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus pins, registered from the sequencer state
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_pins <= '{zone_select_output_n: 1'b1, read_strobe_output_n: 1'b1,
                    lower_write_strobe_n: 1'b1, upper_write_strobe: 1'b1,
                    read_write_direction: 1'b1, addr: {{(ADDR_W-1){1'b0}}, 1'b1}};
    end else begin
      // R3 idle and alignment controls inactive
      bus_pins.zone_select_output_n <= !in_access;
      bus_pins.read_strobe_output_n <= !(in_active && !is_write_ff);
      bus_pins.lower_write_strobe_n <= !(in_active && is_write_ff);
      bus_pins.read_write_direction <= !(in_access && is_write_ff);
      // R4 hold address, lowest line high
      bus_pins.addr <= in_access ? acc_addr_ff : {bus_pins.addr[ADDR_W-1:1], 1'b1};
      // R5 upper strobe or lowest address bit
      if (cfg_ff.bus32) begin
        bus_pins.upper_write_strobe <= !(in_active && is_write_ff);
      end else begin
        bus_pins.upper_write_strobe <= in_access ? acc_addr_ff[0] : 1'b1;
      end
    end
  end

  // Write data drive; held through trail until direction returns high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_data_out <= '0;
      bus_data_oe  <= 1'b0;
    end else begin
      // R9 drive with strobe, release after direction
      // R10 held through write trail
      if (in_active && is_write_ff) begin
        bus_data_out <= wdata_ff;
        bus_data_oe  <= 1'b1;
      end else if (bus_pins.read_write_direction) begin
        bus_data_oe  <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_wait_sample;
    tick && (state_ff == SEQ_STROBE) && hold_wait;
  endsequence

  sequence s_stay_put;
    (state_ff == SEQ_STROBE) && (pos_ff == $past(pos_ff));
  endsequence

  chk_lead_on_rise: assert property ( // R1
    (state_ff == SEQ_STROBE) && ($past(state_ff) != SEQ_STROBE) |-> $past(tick && rise_pt))
    else $error("access lead began off a bus clock rise");

  chk_align_then_go: assert property ( // R2
    tick && (state_ff == SEQ_IDLE) && pend_ff && !rise_pt |=> state_ff == SEQ_ALIGN
      ##[1:8] state_ff == SEQ_STROBE)
    else $error("alignment cycle not followed by access");

  chk_align_inactive: assert property ( // R3
    $past(state_ff) == SEQ_ALIGN |-> bus_pins.zone_select_output_n
      && bus_pins.read_strobe_output_n && bus_pins.lower_write_strobe_n)
    else $error("control active during alignment");

  chk_idle_addr_hold: assert property ( // R4
    !$past(in_access) && !$past(in_access, 2) |-> bus_pins.addr[0]
      && (bus_pins.addr[ADDR_W-1:1] == $past(bus_pins.addr[ADDR_W-1:1])))
    else $error("idle address not held");

  chk_upper_is_a0: assert property ( // R5
    !$past(cfg_ff.bus32) |-> bus_pins.upper_write_strobe == bus_pins.addr[0])
    else $error("upper strobe pin not lowest address in 16-bit mode");

  chk_sample_point: assert property ( // R6
    tick && (state_ff == SEQ_STROBE) && cfg_ff.ready_use_setting && !ready_s
      && !cfg_ff.ready_sampling_style && (elapsed == total_n) |=> s_stay_put)
    else $error("sync ready not sampled at lead plus active");

  chk_wait_resample: assert property ( // R7
    s_wait_sample |=> s_stay_put)
    else $error("low ready did not extend the access");

  chk_async_early: assert property ( // R8
    tick && (state_ff == SEQ_STROBE) && cfg_ff.ready_use_setting && !ready_s
      && cfg_ff.ready_sampling_style && (total_n > 6'h2)
      && (elapsed == total_n - 6'h2) |=> s_stay_put)
    else $error("async ready not sampled two cycles early");

  chk_data_release: assert property ( // R9
    $fell(bus_data_oe) |-> $past(bus_pins.read_write_direction))
    else $error("data released before direction went high");

  chk_trail_hold: assert property ( // R10
    $past(state_ff == SEQ_TRAIL && is_write_ff) |-> bus_data_oe)
    else $error("write data dropped during trail");

  chk_ready_ignored: assert property ( // R11
    tick && (state_ff == SEQ_STROBE) && !cfg_ff.ready_use_setting && (elapsed < total_n)
      |=> pos_ff == $past(elapsed))
    else $error("access stalled with ready unused");

endmodule

// *** rtl/sync2.sv ***
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_ff;

  // ----------------------------------------------------------------
  // Two-stage synchroniser; first stage feeds only the second
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      q       <= '0;
    end else begin
      meta_ff <= d;
      q       <= meta_ff;
    end
  end

endmodule

// *** rtl/tim_tick_div.sv ***
`timescale 1ns/100ps
module tim_tick_div #(
  parameter int DIV = 4
) (
  input  wire logic pclk,
  input  wire logic presetn,
  output logic      tick,
  output logic      first_half
);

  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt_ff;

  initial begin
    if (DIV < 2) $error("tim_tick_div: DIV must be at least 2");
  end

  // ----------------------------------------------------------------
  // Timing-clock enable: one pulse on the last pclk of each period
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else if (tick) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign tick       = (cnt_ff == CW'(DIV - 1));
  assign first_half = (cnt_ff < CW'(DIV / 2));

endmodule

// *** verification/ext_mem_model.sv ***
`timescale 1ns/100ps
module ext_mem_model
  import ext_bus_pkg::*;
#(
  parameter int TDIV = 8
) (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire ext_bus_pkg::bus_pins_s     bus_pins,
  input  wire logic [7:0]                 ready_at,
  output logic                            external_ready_input,
  output logic [ext_bus_pkg::DATA_W-1:0]  bus_data_in
);
  int sel_cnt;

  // ----------------------------------------------------------------
  // Ready line
  // ----------------------------------------------------------------
  // hold ready low
  // Rises early in timing cycle ready_at of the select, so the two-flop sync settles before its end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_cnt              <= 0;
      external_ready_input <= 1'b1;
    end else if (bus_pins.zone_select_output_n) begin
      sel_cnt              <= 0;
      external_ready_input <= 1'b1;  // Pulled up while deselected
    end else begin
      sel_cnt <= sel_cnt + 1;
      if (ready_at != 8'h00 && sel_cnt == (int'(ready_at) - 1) * TDIV) begin
        external_ready_input <= 1'b1;
      end else if (sel_cnt == 0) begin
        external_ready_input <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Released bus toggles so a stale capture cannot pass by luck
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_data_in <= 32'h0000_0000;
    end else if (!bus_pins.zone_select_output_n && bus_pins.read_write_direction) begin
      bus_data_in <= {12'h5a0, bus_pins.addr};
    end else begin
      bus_data_in <= ~bus_data_in;
    end
  end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/100ps
module tb;
  import ext_bus_pkg::*;
  localparam int TD = 8;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               ext_rdy, oe, bclk, b32, is_wr, seen, prev_rw, prev_zone, prev_bclk;
  logic [PADDR_W-1:0] paddr;
  logic [31:0]        pwdata, prdata, exp_wdata, dout, din;
  logic [ADDR_W-1:0]  exp_addr, last_addr;
  logic [7:0]         ready_at;
  bus_pins_s          pins;
  int                 mismatches, checks_done, zcnt, scnt;

  ext_bus_ready_wait_sequencer #(.TIM_DIV_P(TD)) i_ext_bus_ready_wait_sequencer (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .external_ready_input(ext_rdy), .bus_data_in(din), .bus_data_out(dout),
    .bus_data_oe(oe), .bus_clock_output(bclk), .bus_pins(pins));

  ext_mem_model #(.TDIV(TD)) i_ext_mem_model (
    .pclk(pclk), .presetn(presetn), .bus_pins(pins), .ready_at(ready_at),
    .external_ready_input(ext_rdy), .bus_data_in(din));

  // ----------------------------------------------------------------
  // Clock and helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Ends when pready is seen high; only the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      n++;
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    check(n, 0, "apb wait states");
    // Idle edge so the next call never re-drives psel in this time step
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input logic ee,
                        input string what);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    check(r, exp, what);
    check({31'h0, e}, {31'h0, ee}, "slave error");
  endtask

  // Program timing, launch one access, wait for idle, check spans in pclk cycles
  task automatic access(input logic w, input logic use_r, input logic mode, input logic dbl,
                        input logic wide, input int l, input int a, input int t, input int r,
                        input logic [19:0] ad, input logic [31:0] d);
    zone_timing_config_s c;
    logic [31:0] s;
    logic e;
    int fin;
    c = '0;
    c.bus32 = wide; c.timing_doubler_setting = dbl;
    c.ready_sampling_style = mode; c.ready_use_setting = use_r;
    c.write_lead_cycles = l[3:0]; c.write_active_cycles = a[3:0]; c.write_trail_cycles = t[3:0];
    c.read_lead_cycles = l[3:0]; c.read_active_cycles = a[3:0]; c.read_trail_cycles = t[3:0];
    wr(OFS_TIMING, c);
    wr(OFS_ADDR, {12'h0, ad});
    wr(OFS_WDATA, d);
    b32 = wide; is_wr = w; exp_addr = ad; exp_wdata = d; zcnt = 0; scnt = 0;
    ready_at <= r[7:0];
    wr(OFS_CMD, {30'h0, w, 1'b1});
    s = 32'h0;
    while (s[1:0] !== 2'b10) begin
      apb(1'b0, OFS_STATUS, 32'h0, s, e);
    end
    fin = l + a;
    if (use_r && !mode && r > fin) fin = r;
    if (use_r && mode) fin = ((r > fin - ASYNC_EARLY) ? r : fin - ASYNC_EARLY) + ASYNC_EARLY;
    check(scnt, (fin - l) * TD, "strobe span");
    check(zcnt, (fin + t) * TD, "select span");
    if (!w) rd_chk(OFS_RDATA, {12'h5a0, ad}, 1'b0, "read data");
  endtask

  // ----------------------------------------------------------------
  // Pin monitor
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (presetn === 1'b1) begin
      if (pins.zone_select_output_n === 1'b0) begin
        zcnt++;
        last_addr = pins.addr;
        if (!pins.read_strobe_output_n || !pins.lower_write_strobe_n) scnt++;
        if (pins.lower_write_strobe_n === 1'b0) seen = 1'b1;
        check(pins.upper_write_strobe, b32 ? pins.lower_write_strobe_n : exp_addr[0], "upper pin");
        check(pins.addr[19:1], exp_addr[19:1], "access address");
        if (is_wr) check(oe, seen, "drive enable");
        if (is_wr && seen) check(dout, exp_wdata, "write data");
        if (prev_zone === 1'b1) check({prev_bclk, bclk}, 2'b01, "lead start");
      end else begin
        seen = 1'b0;
        check({pins.read_strobe_output_n, pins.lower_write_strobe_n, pins.upper_write_strobe,
               pins.addr[0]}, 4'hf, "idle controls");
        check(pins.addr[19:1], last_addr[19:1], "held address");
      end
      if (pins.read_write_direction === 1'b1 && prev_rw === 1'b1) check(oe, 1'b0, "released");
      prev_rw = pins.read_write_direction;
      prev_zone = pins.zone_select_output_n;
      prev_bclk = bclk;
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    ready_at = 8'h00; mismatches = 0; checks_done = 0; zcnt = 0; scnt = 0;
    b32 = 1'b1; is_wr = 1'b0; seen = 1'b0; prev_rw = 1'b1; prev_zone = 1'b1; prev_bclk = 1'b0;
    exp_addr = '0; last_addr = '0; exp_wdata = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(OFS_TIMING, TIMING_RST, 1'b0, "timing reset");
    rd_chk(OFS_STATUS, 32'h0, 1'b0, "status reset");
    rd_chk(12'h020, 32'h0, 1'b1, "unmapped read");
    // Ready stuck low but unused, then sync and async sampling points
    access(1, 0, 0, 0, 1, 1, 3, 1, 0, 20'h12344, 32'hdead_beef);
    access(0, 1, 0, 0, 1, 1, 3, 1, 4, 20'h00a10, 32'h0);
    access(0, 1, 0, 0, 1, 1, 3, 1, 6, 20'h00a20, 32'h0);
    access(1, 1, 1, 0, 1, 2, 3, 1, 5, 20'h0b000, 32'h1234_5678);
    access(0, 1, 1, 0, 1, 2, 3, 2, 3, 20'h0b004, 32'h0);
    // Narrow bus: upper pin follows the lowest address bit
    access(1, 0, 0, 0, 0, 1, 2, 1, 0, 20'h00101, 32'h0000_a5a5);
    access(1, 0, 0, 0, 0, 1, 2, 1, 0, 20'h00100, 32'h0000_5a5a);
    // Halved bus clock: gaps vary, but every start lands on a bus clock rise, so no alignment cycle
    for (int i = 0; i < 4; i++) begin
      access(1, 0, 0, 1, 1, 1, 1, 1, 0, 20'h00200 + 20'(i * 4), 32'hc0de_0000 + i);
      repeat (i * 3) @(posedge pclk);
    end
    final_report;
  end

  // Watchdog at 60000 pclk cycles, far beyond the under one thousand cycles the tests need
  initial begin
    #300000;
    mismatches++;
    final_report;
  end
endmodule
